// ---- logic/ccsl_pkg.sv ----
package ccsl_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned CTRL_W = 16;
	localparam int unsigned STAT_W = 8;

	// Byte addresses of the word-aligned registers
	localparam logic [ADDR_W-1:0] CTRL_OFF = 16'hFFC8;
	localparam logic [ADDR_W-1:0] TX_OFF = 16'hFFE0;
	localparam logic [ADDR_W-1:0] RX_OFF = 16'hFFE4;
	localparam logic [ADDR_W-1:0] STAT_OFF = 16'hFFE8;
	localparam int unsigned WORD_LSB = 2;

	localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
	// Bits 4, 5, 6 and 9 are reserved: never stored, read as zero
	localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'hFD8F;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Field layout, bit 15 first
	typedef struct packed {
		logic irq_enable;
		logic converter_enable;
		logic input_source_select;
		logic [1:0] input_gain_select;
		logic output_unmute;
		logic rsv9;
		logic clock_source_select;
		logic loopback_select;
		logic [2:0] rsv6_4;
		logic [3:0] volume_select;
	} ccsl_ctrl_s;

	typedef struct packed {
		logic [3:0] rsv;
		logic rx_full_flag;
		logic tx_empty_flag;
		logic rx_overrun_flag;
		logic tx_underrun_flag;
	} ccsl_stat_s;

	typedef logic signed [6:0] ccsl_db_t;

	// Output volume in dB per volume_select code
	localparam ccsl_db_t VOL_DB [16] = '{
		-7'sd15, -7'sd10, -7'sd5, 7'sd0, 7'sd5, 7'sd11, 7'sd17, 7'sd23,
		7'sd5, 7'sd11, 7'sd17, 7'sd23, 7'sd29, 7'sd35, 7'sd35, 7'sd40
	};

	// Analog input gain in dB per input_gain_select code
	localparam ccsl_db_t GAIN_DB [4] = '{-7'sd6, 7'sd0, 7'sd6, 7'sd17};

endpackage

// ---- logic/ccsl_top.sv ----
// Function
// RULE1 - Control bit 7 set feeds A/D modulator output into DAC back end.
// RULE2 - Control bit 8 picks codec clock: squared external input or PLL output.
// RULE3 - Software keeps the codec clock divider at two or more with PLL clock.
// RULE4 - Control bit 10 clear mutes the analog output; set passes it.
// RULE5 - Bits 12:11 pick input gain: -6, 0, 6 or 17 dB.
// RULE6 - Control bit 13 routes primary input when clear, secondary when set.
// RULE7 - Control bit 14 enables the codec; clear puts it in power-down.
// RULE8 - Control bit 15 clear blocks the codec interrupt; set allows it.
// RULE9 - Software writes zero to reserved control bits 4, 5, 6 and 9.
// RULE10 - Status register is 8 bits, read-only; writes never touch flags.
// RULE11 - Sample needed with no new transmit word: flag underrun, resend old.
// RULE12 - Underrun clears on reset, stop, or status read then transmit write.
// RULE13 - New A/D sample over unread one: flag overrun, overwrite receive word.
// RULE14 - Overrun clears on reset, stop, or status read then receive read.
// RULE15 - Transmit empty sets on hand-off to D/A, clears on transmit write.
// RULE16 - Transmit empty forced set on power-down entry, reset and stop.
// RULE17 - Receive full sets when A/D word lands, clears on receive read.
// RULE18 - Receive full cleared on power-down entry, reset and stop.
// RULE19 - Reserved status bits 4 to 7 read as zero.
// RULE20 - Control bits 3:0 pick D/A volume from -15 dB to 40 dB.
// RULE21 - All control bits clear on hardware and software reset.
// RULE22 - Interrupt asserts while enabled and transmit empty or receive full.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module ccsl_top (
	input wire logic aclk, // 250 MHz clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state
	input wire logic soft_reset, // Reset instruction pulse
	input wire logic stop_req, // Stop instruction pulse
	input wire logic [ccsl_pkg::ADDR_W-1:0] awaddr, // Write address
	input wire logic [2:0] awprot, // Unused protection
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [ccsl_pkg::DATA_W-1:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte enables
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [ccsl_pkg::ADDR_W-1:0] araddr, // Read address
	input wire logic [2:0] arprot, // Unused protection
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [ccsl_pkg::DATA_W-1:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic dac_req, // D/A filter wants a sample
	output logic [ccsl_pkg::SAMPLE_W-1:0] dac_sample, // Sample to D/A filter
	output logic dac_sample_valid, // One-cycle strobe with dac_sample
	input wire logic adc_valid, // A/D filter word strobe
	input wire logic [ccsl_pkg::SAMPLE_W-1:0] adc_sample, // A/D filter word
	output ccsl_pkg::ccsl_ctrl_s codec_ctrl, // Stored control fields
	output logic power_down, // Codec section powered down
	output ccsl_pkg::ccsl_db_t volume_db, // Selected D/A volume in dB
	output ccsl_pkg::ccsl_db_t input_gain_db, // Selected input gain in dB
	output logic codec_irq // Codec interrupt request
);

	localparam int unsigned AW = ccsl_pkg::ADDR_W;
	localparam int unsigned SW = ccsl_pkg::SAMPLE_W;

	// Write channel holding
	logic aw_hold_q;
	logic [AW-1:0] aw_addr_q;
	logic w_hold_q;
	logic [ccsl_pkg::DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	// Read channel
	logic rvalid_q;
	logic [ccsl_pkg::DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;

	// Register state
	ccsl_pkg::ccsl_ctrl_s ctrl_q;
	ccsl_pkg::ccsl_ctrl_s ctrl_d;
	logic [SW-1:0] tx_q;
	logic [SW-1:0] rx_q;
	logic tx_empty_q;
	logic tx_empty_d;
	logic rx_full_q;
	logic rx_full_d;
	logic underrun_q;
	logic underrun_d;
	logic overrun_q;
	logic overrun_d;
	logic und_arm_q;
	logic und_arm_d;
	logic ovr_arm_q;
	logic ovr_arm_d;
	logic [SW-1:0] dac_q;
	logic dac_valid_q;
	ccsl_pkg::ccsl_db_t vol_db_q;
	ccsl_pkg::ccsl_db_t gain_db_q;

	// Write path
	wire aw_take = ce & awvalid & awready;
	wire w_take = ce & wvalid & wready;
	wire have_aw = aw_hold_q | aw_take;
	wire have_w = w_hold_q | w_take;
	wire wr_fire = ce & have_aw & have_w & ~bvalid_q;
	wire [AW-1:0] wr_addr = aw_hold_q ? aw_addr_q : awaddr;
	wire [ccsl_pkg::DATA_W-1:0] wr_data = w_hold_q ? w_data_q : wdata;
	wire [3:0] wr_strb = w_hold_q ? w_strb_q : wstrb;
	wire [AW-1:ccsl_pkg::WORD_LSB] wr_word = wr_addr[AW-1:ccsl_pkg::WORD_LSB];
	wire wr_is_ctrl = wr_word == ccsl_pkg::CTRL_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire wr_is_tx = wr_word == ccsl_pkg::TX_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire wr_is_rx = wr_word == ccsl_pkg::RX_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire wr_is_stat = wr_word == ccsl_pkg::STAT_OFF[AW-1:ccsl_pkg::WORD_LSB];
	// Status and receive are read-only; writes there are taken but ignored
	wire wr_hit = wr_is_ctrl | wr_is_tx | wr_is_rx | wr_is_stat; // [RULE10]
	wire wr_any_lane = |wr_strb[1:0];
	wire wr_ctrl = wr_fire & wr_is_ctrl & wr_any_lane;
	wire wr_tx = wr_fire & wr_is_tx & wr_any_lane;
	wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [15:0] ctrl_mask = lane_mask & ccsl_pkg::CTRL_WMASK; // [RULE9]
	wire [15:0] tx_new = (tx_q & ~lane_mask) | (wr_data[15:0] & lane_mask);

	// Read path
	wire rd_fire = ce & arvalid & arready;
	wire [AW-1:ccsl_pkg::WORD_LSB] rd_word = araddr[AW-1:ccsl_pkg::WORD_LSB];
	wire rd_is_ctrl = rd_word == ccsl_pkg::CTRL_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire rd_is_tx = rd_word == ccsl_pkg::TX_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire rd_is_rx = rd_word == ccsl_pkg::RX_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire rd_is_stat = rd_word == ccsl_pkg::STAT_OFF[AW-1:ccsl_pkg::WORD_LSB];
	wire rd_hit = rd_is_ctrl | rd_is_tx | rd_is_rx | rd_is_stat;
	wire rd_stat = rd_fire & rd_is_stat;
	wire rd_rx = rd_fire & rd_is_rx;

	ccsl_pkg::ccsl_stat_s stat_view;
	assign stat_view.rsv = 4'h0; // [RULE19]
	assign stat_view.rx_full_flag = rx_full_q;
	assign stat_view.tx_empty_flag = tx_empty_q;
	assign stat_view.rx_overrun_flag = overrun_q;
	assign stat_view.tx_underrun_flag = underrun_q;

	wire [15:0] ctrl_view = ctrl_q & ccsl_pkg::CTRL_WMASK;
	wire [ccsl_pkg::DATA_W-1:0] rd_word_val =
		rd_is_ctrl ? {16'h0000, ctrl_view} :
		rd_is_stat ? {24'h000000, stat_view} : // [RULE19]
		rd_is_tx ? {16'h0000, tx_q} :
		rd_is_rx ? {16'h0000, rx_q} :
		32'h00000000;

	// Flag events
	wire hard_clr = soft_reset | stop_req;
	wire ctrl_clr = soft_reset; // [RULE21]
	wire active = ctrl_q.converter_enable; // [RULE7]
	wire pd_entry = wr_ctrl & active & ~ctrl_d.converter_enable; // [RULE7]
	// Datapath strobes count only while the section is powered
	wire dac_go = dac_req & active;
	wire adc_go = adc_valid & active;

	assign ctrl_d = ccsl_pkg::ccsl_ctrl_s'((ctrl_q & ~ctrl_mask) | (wr_data[15:0] & ctrl_mask));

	// Transmit empty: hand-off sets and beats a same-cycle write
	always_comb begin
		tx_empty_d = tx_empty_q;
		if (hard_clr | pd_entry) begin
			tx_empty_d = 1'b1; // [RULE16]
		end else if (dac_go) begin
			tx_empty_d = 1'b1; // [RULE15]
		end else if (wr_tx) begin
			tx_empty_d = 1'b0; // [RULE15]
		end
	end

	// Underrun: power-down leaves it alone
	always_comb begin
		underrun_d = underrun_q;
		if (hard_clr) begin
			underrun_d = 1'b0; // [RULE12]
		end else if (dac_go & tx_empty_q) begin
			underrun_d = 1'b1; // [RULE11]
		end else if (wr_tx & und_arm_q) begin
			underrun_d = 1'b0; // [RULE12]
		end
	end

	always_comb begin
		und_arm_d = und_arm_q;
		if (hard_clr | ~underrun_d) begin
			und_arm_d = 1'b0;
		end else if (rd_stat & underrun_q) begin
			und_arm_d = 1'b1; // [RULE12]
		end
	end

	// Receive full
	always_comb begin
		rx_full_d = rx_full_q;
		if (hard_clr | pd_entry) begin
			rx_full_d = 1'b0; // [RULE18]
		end else if (adc_go) begin
			rx_full_d = 1'b1; // [RULE17]
		end else if (rd_rx) begin
			rx_full_d = 1'b0; // [RULE17]
		end
	end

	// Overrun: power-down leaves it alone
	always_comb begin
		overrun_d = overrun_q;
		if (hard_clr) begin
			overrun_d = 1'b0; // [RULE14]
		end else if (adc_go & rx_full_q) begin
			overrun_d = 1'b1; // [RULE13]
		end else if (rd_rx & ovr_arm_q) begin
			overrun_d = 1'b0; // [RULE14]
		end
	end

	always_comb begin
		ovr_arm_d = ovr_arm_q;
		if (hard_clr | ~overrun_d) begin
			ovr_arm_d = 1'b0;
		end else if (rd_stat & overrun_q) begin
			ovr_arm_d = 1'b1; // [RULE14]
		end
	end

	// AXI write address and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
		end else if (ce) begin
			aw_hold_q <= have_aw & ~wr_fire;
			w_hold_q <= have_w & ~wr_fire;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q <= 16'h0000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (ce) begin
			if (aw_take) begin
				aw_addr_q <= awaddr;
			end
			if (w_take) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= ccsl_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? ccsl_pkg::RESP_OKAY : ccsl_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// AXI read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= ccsl_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word_val;
				rresp_q <= rd_hit ? ccsl_pkg::RESP_OKAY : ccsl_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= ccsl_pkg::CTRL_RST; // [RULE21]
		end else if (ce) begin
			if (ctrl_clr) begin
				ctrl_q <= ccsl_pkg::CTRL_RST; // [RULE21]
			end else if (wr_ctrl) begin
				ctrl_q <= ctrl_d;
			end
		end
	end

	// Sample registers; transmit word is kept for resend on underrun
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_q <= ccsl_pkg::SAMPLE_RST;
		end else if (ce & wr_tx) begin
			tx_q <= tx_new;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_q <= ccsl_pkg::SAMPLE_RST;
		end else if (ce & adc_go) begin
			rx_q <= adc_sample; // [RULE13]
		end
	end

	// D/A hand-off; with no fresh word the previous one goes out again
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dac_q <= ccsl_pkg::SAMPLE_RST;
			dac_valid_q <= 1'b0;
		end else if (ce) begin
			dac_valid_q <= dac_go;
			if (dac_go) begin
				dac_q <= tx_q; // [RULE11]
			end
		end
	end

	// Status flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_empty_q <= 1'b1; // [RULE16]
			rx_full_q <= 1'b0; // [RULE18]
			underrun_q <= 1'b0; // [RULE12]
			overrun_q <= 1'b0; // [RULE14]
		end else if (ce) begin
			tx_empty_q <= tx_empty_d;
			rx_full_q <= rx_full_d;
			underrun_q <= underrun_d;
			overrun_q <= overrun_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			und_arm_q <= 1'b0;
			ovr_arm_q <= 1'b0;
		end else if (ce) begin
			und_arm_q <= und_arm_d;
			ovr_arm_q <= ovr_arm_d;
		end
	end

	// Level readouts follow the stored fields one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vol_db_q <= ccsl_pkg::VOL_DB[0];
			gain_db_q <= ccsl_pkg::GAIN_DB[0];
		end else if (ce) begin
			vol_db_q <= ccsl_pkg::VOL_DB[ctrl_q.volume_select]; // [RULE20]
			gain_db_q <= ccsl_pkg::GAIN_DB[ctrl_q.input_gain_select]; // [RULE5]
		end
	end

	// Bus handshakes
	assign awready = ~aw_hold_q & ~bvalid_q;
	assign wready = ~w_hold_q & ~bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = ~rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Codec-side controls; mode bits act straight from the register
	assign codec_ctrl = ccsl_pkg::ccsl_ctrl_s'(ctrl_view); // [RULE1] [RULE2] [RULE4] [RULE6]
	assign power_down = ~ctrl_q.converter_enable; // [RULE7]
	assign volume_db = vol_db_q;
	assign input_gain_db = gain_db_q;
	assign dac_sample = dac_q;
	assign dac_sample_valid = dac_valid_q;

	// Level request: drops in the cycle after the servicing access
	assign codec_irq = ctrl_q.irq_enable & (tx_empty_q | rx_full_q); // [RULE8] [RULE22]

endmodule // ccsl_top

// ---- bench/ccsl_properties.sv ----
`timescale 1ns/100ps
module ccsl_props (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset
	input wire logic ce, // Clock enable
	input wire logic soft_reset, // Reset instruction
	input wire logic arvalid, // Read address valid
	input wire logic arready, // Read address ready
	input wire logic [ccsl_pkg::DATA_W-1:0] rdata, // Read data
	input wire logic rvalid, // Read valid
	input wire logic rready, // Read ready
	input wire logic dac_req, // Sample wanted
	input wire logic [ccsl_pkg::SAMPLE_W-1:0] dac_sample, // Sample out
	input wire logic dac_sample_valid, // Sample strobe
	input ccsl_pkg::ccsl_ctrl_s codec_ctrl, // Control fields
	input wire logic power_down, // Powered down
	input ccsl_pkg::ccsl_db_t volume_db, // Volume
	input ccsl_pkg::ccsl_db_t input_gain_db, // Input gain
	input wire logic codec_irq // Interrupt
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_irq_gate: assert property (codec_irq |-> codec_ctrl.irq_enable)
		else $error("interrupt raised while disabled");
	a_pd_track: assert property (power_down == !codec_ctrl.converter_enable)
		else $error("power down does not follow enable");
	a_dac_cause: assert property (dac_sample_valid |-> $past(dac_req && ce && !power_down))
		else $error("sample strobe without request");
	a_dac_answer: assert property (dac_req && ce && !power_down |=> dac_sample_valid)
		else $error("request not answered");
	a_dac_hold: assert property ($past(aresetn) && !dac_sample_valid |-> $stable(dac_sample))
		else $error("sample changed without strobe");
	a_ctrl_clear: assert property ($rose(aresetn) || $past(soft_reset && ce) |-> codec_ctrl == '0)
		else $error("control not cleared");
	a_gain_map: assert property ($past(aresetn) |-> input_gain_db ==
		($past(codec_ctrl.input_gain_select) == 2'h3 ? 7'sd17 :
		$past(codec_ctrl.input_gain_select) == 2'h2 ? 7'sd6 :
		$past(codec_ctrl.input_gain_select) == 2'h1 ? 7'sd0 : -7'sd6))
		else $error("input gain mismatch");
	a_vol_top: assert property ($past(aresetn) && $past(codec_ctrl.volume_select) == 4'hF
		|-> volume_db == 7'sd40)
		else $error("top volume mismatch");
	a_rd_answer: assert property (arvalid && arready && ce |=> rvalid)
		else $error("read not answered");
	a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_rd_release: assert property (rvalid && rready && ce |=> !rvalid)
		else $error("read valid held after handshake");
endmodule // ccsl_props
bind ccsl_top ccsl_props u_props (.*);

// ---- bench/ccsl_codec_model.sv ----
`timescale 1ns/100ps
module ccsl_codec_model (
	input wire logic aclk, // Clock
	input wire logic [15:0] dac_sample, // Sample from block
	input wire logic dac_sample_valid, // Sample strobe
	output logic dac_req, // Sample wanted
	output logic adc_valid, // A/D word strobe
	output logic [15:0] adc_sample // A/D word
);
	logic [15:0] got;
	int outs;
	initial begin
		dac_req = 1'b0;
		adc_valid = 1'b0;
		adc_sample = 16'hA5C3;
		outs = 0;
	end
	always @(posedge aclk) begin
		if (dac_sample_valid) begin
			got <= dac_sample;
			outs <= outs + 1;
		end
	end
	task automatic pull();
		dac_req <= 1'b1;
		@(posedge aclk);
		dac_req <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic push(input logic [15:0] d);
		adc_valid <= 1'b1;
		adc_sample <= d;
		@(posedge aclk);
		adc_valid <= 1'b0;
		// Released line shows the inverse, not a stale copy
		adc_sample <= ~d;
		repeat (2) @(posedge aclk);
	endtask
endmodule // ccsl_codec_model

// ---- bench/ccsl_top_bench.sv ----
`timescale 1ns/100ps
module ccsl_top_bench;
	localparam logic [15:0] CT = ccsl_pkg::CTRL_OFF;
	localparam logic [15:0] ST = ccsl_pkg::STAT_OFF;
	localparam logic [15:0] TX = ccsl_pkg::TX_OFF;
	localparam logic [15:0] RX = ccsl_pkg::RX_OFF;
	logic aclk, aresetn, ce, soft_reset, stop_req, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready, dac_req, dac_sample_valid;
	logic adc_valid, power_down, codec_irq;
	logic [15:0] awaddr, araddr, dac_sample, adc_sample;
	logic [2:0] awprot, arprot;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, r;
	ccsl_pkg::ccsl_ctrl_s codec_ctrl;
	ccsl_pkg::ccsl_db_t volume_db, input_gain_db;
	int fails, check_count;
	int vol[16] = '{-15, -10, -5, 0, 5, 11, 17, 23, 5, 11, 17, 23, 29, 35, 35, 40};
	int gn[4] = '{-6, 0, 6, 17};
	int bits[6] = '{7, 8, 10, 13, 14, 15};
	ccsl_top u_dut (.*);
	ccsl_codec_model u_codec (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic b;
		b = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				b = 1'b0;
			end
		end
		@(posedge aclk);
	endtask
	task automatic rd(input logic [15:0] a);
		logic b;
		b = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (b) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				b = 1'b0;
			end
		end
		@(posedge aclk);
	endtask
	task automatic results();
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		// Whole sequence needs well under a thousand cycles
		repeat (20000) @(posedge aclk);
		fails++;
		results();
	end
	initial begin
		{aresetn, soft_reset, stop_req, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, awprot, arprot, wdata} = '0;
		ce = 1'b1;
		wstrb = 4'hF;
		fails = 0;
		check_count = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CT);
		chk(v, 32'h0);
		rd(ST);
		chk(v, 32'h4);
		chk({power_down, codec_irq}, 32'h2);
		for (int i = 0; i < 16; i++) begin
			wr(CT, {19'h0, i[1:0], 7'h0, i[3:0]});
			chk(volume_db, vol[i]);
			chk(input_gain_db, gn[i%4]);
		end
		foreach (bits[k]) begin
			// Divider sits outside this block; PLL pick is a field test only
			wr(CT, 32'h1 << bits[k]);
			chk(codec_ctrl, 32'h1 << bits[k]);
		end
		wr(CT, 32'hFFFF);
		rd(CT);
		chk(v, 32'hFD8F);
		wr(ST, 32'hFF);
		chk(r, ccsl_pkg::RESP_OKAY);
		rd(ST);
		chk(v, 32'h4);
		chk(r, ccsl_pkg::RESP_OKAY);
		wr(16'h0010, 32'h0);
		chk(r, ccsl_pkg::RESP_SLVERR);
		rd(16'h0010);
		chk(r, ccsl_pkg::RESP_SLVERR);
		wr(CT, 32'hC400);
		chk(codec_irq, 32'h1);
		wr(TX, 32'h1234);
		chk(codec_irq, 32'h0);
		rd(ST);
		chk(v, 32'h0);
		u_codec.pull();
		chk(u_codec.got, 32'h1234);
		rd(ST);
		chk(v, 32'h4);
		u_codec.pull();
		chk(u_codec.got, 32'h1234);
		wr(TX, 32'h5678);
		rd(ST);
		chk(v, 32'h1);
		wr(TX, 32'h9ABC);
		rd(ST);
		chk(v, 32'h0);
		u_codec.push(16'hAAAA);
		rd(ST);
		chk(v, 32'h8);
		u_codec.push(16'h5555);
		rd(ST);
		chk(v, 32'hA);
		rd(RX);
		chk(v, 32'h5555);
		rd(ST);
		chk(v, 32'h0);
		u_codec.push(16'h1111);
		u_codec.pull();
		u_codec.pull();
		chk(u_codec.got, 32'h9ABC);
		rd(ST);
		chk(v, 32'hD);
		wr(CT, 32'h0400);
		rd(ST);
		chk(v, 32'h5);
		u_codec.pull();
		chk(u_codec.outs, 32'h4);
		stop_req <= 1'b1;
		@(posedge aclk);
		stop_req <= 1'b0;
		rd(ST);
		chk(v, 32'h4);
		rd(CT);
		chk(v, 32'h0400);
		wr(CT, 32'hC400);
		// Frozen clock enable: the A/D word must be ignored
		ce <= 1'b0;
		u_codec.push(16'h3333);
		ce <= 1'b1;
		rd(ST);
		chk(v, 32'h4);
		u_codec.push(16'h2222);
		rd(ST);
		chk(v, 32'hC);
		soft_reset <= 1'b1;
		@(posedge aclk);
		soft_reset <= 1'b0;
		rd(CT);
		chk(v, 32'h0);
		rd(ST);
		chk(v, 32'h4);
		results();
	end
endmodule // ccsl_top_bench
